/* File: verilog/ssw_defs.vh */
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH
`define SSW_CLK_HZ 40000000
`define SSW_TICK_HZ 1000
`define SSW_TICK_DIV (`SSW_CLK_HZ / `SSW_TICK_HZ)
`define SSW_RELEASE_MS 200
`define SSW_WD_MS_00 1400
`define SSW_WD_MS_01 600
`define SSW_WD_MS_10 200
`define SSW_WD_OFF 2'b11
`define SSW_WD_RESET_VAL 2'b11
`define SSW_PROG_SLAVE 8'hA0
`define SSW_PROG_RAISE 8'h01
`define SSW_PROG_CLEAR 8'h03
`define SSW_PROG_DATA 8'h00
`define SSW_THR_W 4
`define SSW_THR_MIN 4'h0
`endif

/* File: verilog/ssw_ms_timer.v */
`timescale 1ns/1ps
`default_nettype none
// divides the 40 MHz clock to a 1 ms enable pulse
module ssw_ms_timer #(
  parameter integer DIV = 40000
) (
  input wire clk_in,
  input wire reset_in,
  output reg tick_out
);
  reg [31:0] cnt_q;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ssw_supervisor.v */
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.vh"
module ssw_supervisor #(
  parameter integer TICK_DIV = `SSW_TICK_DIV,
  parameter integer RELEASE_MS = `SSW_RELEASE_MS,
  parameter integer WD_MS_00 = `SSW_WD_MS_00,
  parameter integer WD_MS_01 = `SSW_WD_MS_01,
  parameter integer WD_MS_10 = `SSW_WD_MS_10
) (
  input wire clk_in,
  input wire reset_in,
  input wire supply_ok_in,
  input wire scl_in,
  input wire sda_in,
  input wire wp_in,
  input wire programming_high_voltage_in,
  input wire period_wr_in,
  input wire watchdog_period_hi_in,
  input wire watchdog_period_lo_in,
  input wire nv_busy_in,
  output reg sys_reset_out,
  output reg bus_enable_out,
  output reg nv_write_allow_out,
  output reg watchdog_period_hi_out,
  output reg watchdog_period_lo_out,
  output reg [`SSW_THR_W-1:0] trip_threshold_out,
  output reg prog_busy_out,
  output reg array_write_block_out
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_BYTE = 3'h2;
  localparam [2:0] S_DATA = 3'h3;
  localparam [2:0] S_OK = 3'h4;
  localparam [2:0] S_SKIP = 3'h5;
  localparam [1:0] WD_RST = `SSW_WD_RESET_VAL;

  function [31:0] wd_limit;
    input [1:0] code;
    begin
      case (code)
        2'b00: wd_limit = WD_MS_00;
        2'b01: wd_limit = WD_MS_01;
        2'b10: wd_limit = WD_MS_10;
        default: wd_limit = 32'h0;
      endcase
    end
  endfunction

  wire tick;
  ssw_ms_timer #(.DIV(TICK_DIV)) u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_out(tick)
  );

  reg scl_q;
  reg sda_q;
  reg [31:0] rel_q;
  reg [31:0] wd_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg raise_q;
  reg armed_raise_q;
  reg busy_q;
  reg nv_run_q;
  reg [`SSW_THR_W-1:0] thr_q;

  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
  wire rise_c = scl_in & ~scl_q;
  wire fall_c = ~scl_in & scl_q;
  wire [1:0] wd_code = {watchdog_period_hi_out, watchdog_period_lo_out};
  wire wd_fire = (wd_code != `SSW_WD_OFF) && (wd_q >= wd_limit(wd_code));
  wire [7:0] byte_c = {sh_q[6:0], sda_in};

  // bus line history for start, stop and edge detection
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nv_run_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      // a write that was already running keeps going through a brownout
      nv_run_q <= nv_busy_in;
    end
  end

  // release delay and watchdog share the one reset output
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rel_q <= 32'h0;
      wd_q <= 32'h0;
      sys_reset_out <= 1'b1;
    end else if (!supply_ok_in) begin
      rel_q <= 32'h0;
      sys_reset_out <= 1'b1;
    end else if (rel_q < RELEASE_MS) begin
      if (tick) begin
        rel_q <= rel_q + 32'h1;
      end
      sys_reset_out <= 1'b1;
      wd_q <= 32'h0;
    end else if (wd_fire) begin
      // watchdog bite reuses the release delay as the reset pulse width
      rel_q <= 32'h0;
      sys_reset_out <= 1'b1;
      wd_q <= 32'h0;
    end else begin
      sys_reset_out <= 1'b0;
      if (sda_in != sda_q || start_c) begin
        wd_q <= 32'h0;
      end else if (tick) begin
        wd_q <= wd_q + 32'h1;
      end
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_enable_out <= 1'b0;
      nv_write_allow_out <= 1'b0;
    end else begin
      bus_enable_out <= supply_ok_in;
      nv_write_allow_out <= supply_ok_in & ~busy_q;
    end
  end

  // period bits come up as watchdog off and move only on an unlocked request
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      watchdog_period_hi_out <= WD_RST[1];
      watchdog_period_lo_out <= WD_RST[0];
    end else if (period_wr_in && !wp_in && supply_ok_in && !nv_run_q) begin
      watchdog_period_hi_out <= watchdog_period_hi_in;
      watchdog_period_lo_out <= watchdog_period_lo_in;
    end
  end

  // program sequence decoder; a brownout drops any frame half way
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      raise_q <= 1'b0;
      armed_raise_q <= 1'b0;
      busy_q <= 1'b0;
      thr_q <= `SSW_THR_MIN;
    end else begin
      if (!supply_ok_in) begin
        st_q <= S_IDLE;
      end else if (start_c) begin
        st_q <= programming_high_voltage_in ? S_ADDR : S_SKIP;
        bit_q <= 4'h0;
      end else if (stop_c) begin
        if (st_q == S_OK && !busy_q) begin
          busy_q <= 1'b1;
          armed_raise_q <= raise_q;
        end
        st_q <= S_IDLE;
      end else if (rise_c && st_q != S_IDLE && st_q != S_SKIP && st_q != S_OK) begin
        if (bit_q == 4'h8) begin
          bit_q <= 4'h0;
        end else begin
          sh_q <= byte_c;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            case (st_q)
              S_ADDR: st_q <= (byte_c == `SSW_PROG_SLAVE) ? S_BYTE : S_SKIP;
              S_BYTE: begin
                raise_q <= (byte_c == `SSW_PROG_RAISE);
                st_q <= (byte_c == `SSW_PROG_RAISE || byte_c == `SSW_PROG_CLEAR)
                  ? S_DATA : S_SKIP;
              end
              S_DATA: st_q <= (byte_c == `SSW_PROG_DATA) ? S_OK : S_SKIP;
              default: st_q <= S_SKIP;
            endcase
          end
        end
      end
      // high voltage dropping back finishes the programming cycle;
      // the old busy_q is tested, so a stop in the same cycle still wins
      if (busy_q && !programming_high_voltage_in) begin
        busy_q <= 1'b0;
        // stored threshold abstracted as a code; raise bumps it, clear sets minimum
        if (armed_raise_q) begin
          thr_q <= thr_q + {{(`SSW_THR_W-1){1'b0}}, 1'b1};
        end else begin
          thr_q <= `SSW_THR_MIN;
        end
      end
    end
  end

  // registered copies so every output leaves straight from a flip-flop
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      trip_threshold_out <= `SSW_THR_MIN;
      prog_busy_out <= 1'b0;
      array_write_block_out <= 1'b0;
    end else begin
      trip_threshold_out <= thr_q;
      prog_busy_out <= busy_q;
      array_write_block_out <= busy_q;
    end
  end
endmodule
`default_nettype wire

/* File: dv/ssw_supervisor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_sup_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic supply_ok_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  input wire logic sys_reset_out,
  input wire logic bus_enable_out,
  input wire logic nv_write_allow_out,
  input wire logic watchdog_period_hi_out,
  input wire logic watchdog_period_lo_out,
  input wire logic prog_busy_out,
  input wire logic array_write_block_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire [1:0] per = {watchdog_period_hi_out, watchdog_period_lo_out};
  sequence s_dip;
    sys_reset_out && !supply_ok_in ##1 supply_ok_in;
  endsequence
  sequence s_freed;
    $fell(sys_reset_out) ##1 supply_ok_in [*8];
  endsequence
  AST_LOW_RST: assert property (!supply_ok_in |=> sys_reset_out) else $error("no reset");
  AST_BUS_OFF: assert property (!supply_ok_in |=> !bus_enable_out) else $error("bus open");
  AST_NV_OFF: assert property (!supply_ok_in |=> !nv_write_allow_out) else $error("nv open");
  AST_HOLD: assert property (s_dip |-> sys_reset_out [*8]) else $error("early release");
  AST_LOCK: assert property (wp_in [*3] |=> $stable(per)) else $error("period unlocked");
  AST_BLK: assert property (array_write_block_out == prog_busy_out) else $error("array open");
  AST_STOP: assert property ($rose(prog_busy_out) |-> $past(scl_in) && $past(sda_in))
    else $error("program without stop");
  AST_WD_OFF: assert property (per == 2'b11 && supply_ok_in && !sys_reset_out |=> !sys_reset_out)
    else $error("bite while off");
  AST_WD_NEW: assert property (s_freed |-> !sys_reset_out) else $error("stale watchdog");
endmodule
bind ssw_supervisor ssw_sup_chk ssw_sup_chk_i (.clk_in, .reset_in, .supply_ok_in, .scl_in,
  .sda_in, .wp_in, .sys_reset_out, .bus_enable_out, .nv_write_allow_out, .watchdog_period_hi_out,
  .watchdog_period_lo_out, .prog_busy_out, .array_write_block_out);
`default_nettype wire

/* File: dv/ssw_i2c_mstr.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_i2c_mstr (
  input wire logic clk_in,
  output logic scl_out,
  output logic sda_out,
  output logic hv_out
);
  // released lines read high, as the pulled-up bus does
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    hv_out = 1'b0;
  end
  task automatic step(input logic c, input logic d);
    scl_out = c;
    sda_out = d;
    repeat (2) @(negedge clk_in);
  endtask
  // scl falls before sda moves, so no bit edge is mistaken for start or stop
  task automatic bt(input logic d);
    step(1'b0, sda_out);
    step(1'b0, d);
    step(1'b1, d);
  endtask
  task automatic ping();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    bt(1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic prog(input logic [7:0] adr, input logic [7:0] dat);
    logic [23:0] frame;
    frame = {8'hA0, adr, dat};
    hv_out = 1'b1;
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    for (int i = 23; i >= 0; i--) begin
      bt(frame[i]);
      if (i % 8 == 0) bt(1'b1);
    end
    bt(1'b0);
    step(1'b1, 1'b1);
    hv_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: dv/supply_supervisor_watchdog_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  localparam int TD = 4;
  localparam int RM = 3;
  localparam int WD [3] = '{8, 6, 4};
  localparam logic [19:0] TAB [5] = '{20'h10100, 20'h20100, 20'h2015A, 20'h00300, 20'h10100};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic supply_ok_in = 1'b0;
  logic wp_in = 1'b0;
  logic period_wr_in = 1'b0;
  logic [1:0] code = 2'b00;
  logic nv_busy_in = 1'b0;
  wire scl_in, sda_in, hv, sys_reset_out, bus, nv, hi, lo, pb;
  wire [3:0] thr;
  wire [9:0] obs = {sys_reset_out, bus, nv, hi, lo, pb, thr};
  logic [9:0] q [$];
  logic [9:0] e;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  event ev;
  always #12.5 clk_in = ~clk_in;
  ssw_i2c_mstr ssw_i2c_mstr_i (.clk_in, .scl_out(scl_in), .sda_out(sda_in), .hv_out(hv));
  ssw_supervisor #(.TICK_DIV(TD), .RELEASE_MS(RM), .WD_MS_00(WD[0]), .WD_MS_01(WD[1]),
    .WD_MS_10(WD[2])) ssw_supervisor_i (.clk_in, .reset_in, .supply_ok_in, .scl_in, .sda_in,
    .wp_in, .programming_high_voltage_in(hv), .period_wr_in, .watchdog_period_hi_in(code[1]),
    .watchdog_period_lo_in(code[0]), .nv_busy_in, .sys_reset_out, .bus_enable_out(bus),
    .nv_write_allow_out(nv), .watchdog_period_hi_out(hi), .watchdog_period_lo_out(lo),
    .trip_threshold_out(thr), .prog_busy_out(pb), .array_write_block_out());
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic note(input logic [9:0] x);
    q.push_back(x);
    ->ev;
  endtask
  always @(ev) while (q.size() > 0) begin
    e = q.pop_front();
    num_checks++;
    if (obs !== e) begin
      num_errors++;
      $display("ERROR %0t outputs %h expected %h", $time, obs, e);
    end
  end
  // bounded: a reset edge that never comes ends the run
  task automatic wait_rst(input logic lvl, input int lo_n, input int hi_n);
    n = 0;
    while (sys_reset_out !== lvl && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    num_checks++;
    if (n < lo_n || n > hi_n) begin
      num_errors++;
      $display("ERROR %0t reset edge after %0d cycles", $time, n);
      if (n >= 300) end_sim();
    end
  endtask
  task automatic setp(input logic [1:0] c);
    code = c;
    period_wr_in = 1'b1;
    @(negedge clk_in);
    period_wr_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  initial begin
    void'($urandom(32'h00E3));
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
    note(10'h260);
    supply_ok_in = 1'b1;
    wait_rst(1'b0, (RM - 1) * TD, RM * TD + 3);
    note(10'h1E0);
    wp_in = 1'b1;
    repeat (3) @(negedge clk_in);
    setp(2'($urandom_range(0, 2)));
    note(10'h1E0);
    wp_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      ssw_i2c_mstr_i.ping();
      setp(2'(i));
      note({3'b011, 2'(i), 5'h00});
      repeat (3) ssw_i2c_mstr_i.ping();
      note({3'b011, 2'(i), 5'h00});
      wait_rst(1'b1, (WD[i] - 1) * TD - 2, WD[i] * TD + 4);
      wait_rst(1'b0, (RM - 1) * TD, RM * TD + 3);
    end
    ssw_i2c_mstr_i.ping();
    setp(2'b11);
    note(10'h1E0);
    nv_busy_in = 1'b1;
    supply_ok_in = 1'b0;
    repeat (2) @(negedge clk_in);
    note(10'h260);
    setp(2'b00);
    ssw_i2c_mstr_i.prog(8'h01, 8'h00);
    note(10'h260);
    nv_busy_in = 1'b0;
    supply_ok_in = 1'b1;
    wait_rst(1'b0, (RM - 1) * TD, RM * TD + 3);
    foreach (TAB[k]) begin
      ssw_i2c_mstr_i.prog(TAB[k][15:8], TAB[k][7:0]);
      note({6'h1E, TAB[k][19:16]});
    end
    end_sim();
  end
endmodule
`default_nettype wire
